/* hw/bmss_top.sv */
/*
 * bmss_top: topology check, submodule and module supervision, output
 * clearing, status bits and timed acknowledgment of a fieldbus head.
 * Assumes: topology, submodule and module inputs come from logic on the
 * same clock; link-up and factory switch are pins; sys_restart is a
 * one-cycle pulse per system restart; rst_n is the power-up reset.
 */
// Design decisions made here: strobed register access and the register addresses.
// Summary of operation
// (RULE1) first start stores topology if config matches
// (RULE2) restart flags moved or re-lined devices
// (RULE3) added or removed devices flag topology error
// (RULE4) matching topology resumes after next restart
// (RULE5) substitute without major safe change passes
// (RULE6) switch factory reset relearns topology next start
// (RULE7) removed submodule: red, green flash, fault red
// (RULE8) removed safety submodule bit cleared at once
// (RULE9) identical reinsertion restores bit and indicators
// (RULE10) correct submodule operational without restart
// (RULE11) lost module and downstream inactive till restart
// (RULE12) output data zero on power, link loss, stop
// (RULE13) basic and extended layout with diag byte
// (RULE14) run bit set only while delivering data
// (RULE15) line error on fault, interference, cable length
// (RULE16) system error on any, general on head error
// (RULE17) errors clear on cause gone or held ack
// (RULE18) controller holds ack at least 100 ms
// (RULE19) head exposes no safe bits, only status
// (RULE20) indicator flash rate 1 to 255 tenths hertz
// (RULE21) ack high time counted before error clears
`timescale 1ns/1ps
module bmss_top
  import bmss_pkg::*;
#(
  parameter int NSUB   = 4,
  parameter int NMOD   = 4,
  parameter int TW     = 32,
  parameter int OUT_W  = 8,
  parameter int CLK_HZ = CLK_HZ_DEF,
  parameter int ACK_CYC = (CLK_HZ / MS_PER_S) * ACK_HOLD_MS
) (
  input  wire logic             clock,        // 125 MHz
  input  wire logic             rst_n,        // power-up reset
  input  wire bmss_req_t        req,          // register request
  output logic [31:0]           rdata,        // read data, cycle after
  input  wire logic             sys_restart,  // restart pulse
  input  wire logic             factory_sw,   // factory switch pin
  input  wire logic [TW-1:0]    topo_now,     // discovered topology
  input  wire logic             safe_diff,    // major safe-data change
  input  wire logic             cfg_match,    // controller config fits
  input  wire logic [NSUB-1:0]  sub_present,  // submodule plugged
  input  wire logic [NSUB-1:0]  sub_match,    // identical, same align
  input  wire logic [NSUB-1:0]  sub_safe,     // has safety function
  input  wire logic [NSUB-1:0]  sub_bits,     // submodule state bits
  output logic [NSUB-1:0]       sub_out,      // bits sent on bus
  output logic [NSUB-1:0]       slot_red,     // slot indicator red
  output logic [NSUB-1:0]       slot_grn,     // slot indicator green
  output logic                  sys_fault_red,// system fault ind.
  input  wire logic [NMOD-1:0]  mod_link,     // module chain links
  output logic [NMOD-1:0]       mod_active,   // modules in service
  input  wire bmss_line_t [1:0] line_cause,   // line error causes
  input  wire logic             head_fault,   // head internal error
  input  wire logic             link_pin,     // fieldbus link up
  input  wire logic             iops_good,    // controller running
  input  wire logic [OUT_W-1:0] plc_out,      // output data in
  output logic [OUT_W-1:0]      out_data,     // evaluated outputs
  input  wire logic             ack_in,       // general_ack_bit
  output logic [7:0]            status_byte,  // non-safe input bits
  output logic [7:0]            diag_byte     // extended diag byte
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // a flash rate of zero would freeze the pattern, so it acts as 1
  function automatic logic [7:0] fl_rate(input logic [7:0] v);
    fl_rate = (v == 8'h00) ? FL_MIN : v;
  endfunction

  localparam logic [31:0] HALF_T = 32'(CLK_HZ * TENTHS_HALF);
  localparam logic [31:0] ACK_T  = 32'(ACK_CYC - 1);

  bmss_state_t       st_q;
  logic [TW-1:0]     topo_q;
  logic              vld_q;
  logic [2:0]        lnk_s_q;
  logic [2:0]        fac_s_q;
  logic              lnk_q;
  logic              fac_q;
  logic              ctrl_ext_q;
  logic [7:0]        fl_q [2];
  logic [31:0]       acc_q [2];
  logic [1:0]        ph_q [2];
  logic [NSUB-1:0]   rem_q;
  logic [NSUB-1:0]   sub_q;
  logic [NSUB-1:0]   red_q;
  logic [NSUB-1:0]   grn_q;
  logic              sf_q;
  logic [NMOD-1:0]   lost_q;
  logic [NMOD-1:0]   act_q;
  logic [3:0]        cz_q;
  logic [3:0]        err_q;
  logic [31:0]       ack_cnt_q;
  logic [OUT_W-1:0]  out_q;
  logic [7:0]        sb_q;
  logic [7:0]        dg_q;
  logic [31:0]       rd_q;
  logic [3:0]        cz;
  logic              ack_fire;
  logic              topo_ok;
  logic              run;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  // a level counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk_s_q <= 3'h0;
      fac_s_q <= 3'h0;
      lnk_q   <= 1'b0;
      fac_q   <= 1'b0;
    end else begin
      lnk_s_q <= {lnk_s_q[1:0], link_pin};
      fac_s_q <= {fac_s_q[1:0], factory_sw};
      if (lnk_s_q[1] == lnk_s_q[2]) lnk_q <= lnk_s_q[2];
      if (fac_s_q[1] == fac_s_q[2]) fac_q <= fac_s_q[2];
    end
  end

  // -------------------------------------------------------------
  // topology supervision
  // -------------------------------------------------------------
  // equal types with no major safe change count as the same device
  assign topo_ok = (topo_now == topo_q) && !safe_diff; // [RULE5]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_BOOT;
      vld_q  <= 1'b0;
      topo_q <= '0;
    end else if (sys_restart) begin
      st_q <= ST_BOOT;
      if (fac_q) vld_q <= 1'b0; // [RULE6]
    end else begin
      case (st_q)
        ST_BOOT: begin
          if (!vld_q) begin
            if (cfg_match) begin
              topo_q <= topo_now; // [RULE1] [RULE6]
              vld_q  <= 1'b1;
              st_q   <= ST_RUN;
            end else begin
              st_q <= ST_NOCFG;
            end
          end else if (topo_ok) begin
            st_q <= ST_RUN; // [RULE4]
          end else begin
            st_q <= ST_SWAP; // [RULE2] [RULE3]
          end
        end
        ST_RUN:   st_q <= ST_RUN;
        ST_SWAP:  st_q <= ST_SWAP;  // only a restart leaves it
        ST_NOCFG: st_q <= ST_NOCFG;
        default:  st_q <= ST_BOOT;
      endcase
    end
  end

  // -------------------------------------------------------------
  // register port
  // -------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ext_q <= 1'b0;
      fl_q[0]    <= FL_RST;
      fl_q[1]    <= FL_RST;
    end else if (req.wr) begin
      case (req.addr)
        A_CTRL:    ctrl_ext_q <= req.wdata[CTRL_EXT]; // [RULE13]
        A_FL_SLOT: fl_q[0]    <= req.wdata[7:0]; // [RULE20]
        A_FL_SF:   fl_q[1]    <= req.wdata[7:0]; // [RULE20]
        default:   ;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 32'h0;
    end else if (req.rd) begin
      case (req.addr)
        A_CTRL:    rd_q <= {31'h0, ctrl_ext_q};
        A_STAT:    rd_q <= {vld_q, 5'h00, st_q, dg_q, sb_q,
                            4'(rem_q), 4'(act_q)};
        A_FL_SLOT: rd_q <= {24'h0, fl_q[0]};
        A_FL_SF:   rd_q <= {24'h0, fl_q[1]};
        default:   rd_q <= 32'h0;
      endcase
    end else begin
      rd_q <= 32'h0;
    end
  end

  // -------------------------------------------------------------
  // flash generators: slot (0) and system fault (1)
  // -------------------------------------------------------------
  // phase accumulator avoids a divider; rate is tenths of a hertz
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 2; k++) begin
        acc_q[k] <= 32'h0;
        ph_q[k]  <= 2'h0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (acc_q[k] >= HALF_T) begin
          acc_q[k] <= acc_q[k] - HALF_T + 32'(fl_rate(fl_q[k]));
          ph_q[k]  <= ph_q[k] + 2'h1; // [RULE20]
        end else begin
          acc_q[k] <= acc_q[k] + 32'(fl_rate(fl_q[k]));
        end
      end
    end
  end

  // -------------------------------------------------------------
  // submodules
  // -------------------------------------------------------------
  // state follows the slot at once, no restart needed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= '0;
      sub_q <= '0;
      red_q <= '0;
      grn_q <= '0;
    end else begin
      for (int i = 0; i < NSUB; i++) begin
        rem_q[i] <= !(sub_present[i] && sub_match[i]); // [RULE10]
        // a missing safety submodule never reports its old bit
        sub_q[i] <= (sub_present[i] && sub_match[i]) ? sub_bits[i]
                  : (sub_safe[i] ? 1'b0 : sub_q[i]); // [RULE8] [RULE9]
        // one green quarter in every four half periods
        red_q[i] <= rem_q[i] && (ph_q[0] != 2'h0); // [RULE7]
        grn_q[i] <= rem_q[i] && (ph_q[0] == 2'h0); // [RULE7] [RULE9]
      end
    end
  end

  // steady red for a removed submodule or lost module, flashing for topology trouble
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sf_q <= 1'b0;
    end else begin
      sf_q <= (|rem_q) || (|lost_q) // [RULE7]
           || ((st_q[1]) && ph_q[1][0]);
    end
  end

  // -------------------------------------------------------------
  // module chain
  // -------------------------------------------------------------
  // a break silences everything behind it until a restart
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lost_q <= '0;
      act_q  <= '0;
    end else begin
      for (int m = 0; m < NMOD; m++) begin
        lost_q[m] <= !mod_link[m] || (lost_q[m] && !sys_restart);
      end
      act_q[0] <= !lost_q[0]; // [RULE11]
      for (int m = 1; m < NMOD; m++) begin
        act_q[m] <= act_q[m-1] && !lost_q[m]; // [RULE11]
      end
    end
  end

  // -------------------------------------------------------------
  // error bits and acknowledgment timer
  // -------------------------------------------------------------
  always_comb begin
    cz[0] = |line_cause[0]; // [RULE15]
    cz[1] = |line_cause[1]; // [RULE15]
    cz[3] = head_fault || st_q[1]; // [RULE16]
    cz[2] = cz[0] || cz[1] || cz[3] || (|rem_q)
         || (|lost_q); // [RULE16]
  end

  // ack must be high without a gap for the whole hold time
  assign ack_fire = ack_in && (ack_cnt_q == ACK_T); // [RULE21]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_cnt_q <= 32'h0;
    end else if (!ack_in) begin
      ack_cnt_q <= 32'h0;
    end else if (ack_cnt_q <= ACK_T) begin
      ack_cnt_q <= ack_cnt_q + 32'h1; // [RULE21]
    end
  end

  // a new cause beats an ack landing in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cz_q  <= 4'h0;
      err_q <= 4'h0;
    end else begin
      cz_q  <= cz;
      err_q <= (cz & ~cz_q)
             | (err_q & cz & {4{!ack_fire}}); // [RULE17]
    end
  end

  // -------------------------------------------------------------
  // fieldbus data
  // -------------------------------------------------------------
  assign run = (st_q == ST_RUN) && lnk_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0; // [RULE12]
      sb_q  <= 8'h00;
      dg_q  <= DG_NONE;
    end else begin
      out_q <= (lnk_q && iops_good) ? plc_out : '0; // [RULE12]
      // status only; the head carries no safe bits
      sb_q  <= 8'h00; // [RULE19]
      sb_q[SB_RUN] <= run; // [RULE14]
      sb_q[SB_ML1] <= err_q[0]; // [RULE15]
      sb_q[SB_ML2] <= err_q[1];
      sb_q[SB_SYS] <= err_q[2]; // [RULE16]
      sb_q[SB_GEN] <= err_q[3];
      // basic layout keeps the diag byte at zero
      if (!ctrl_ext_q)         dg_q <= DG_NONE; // [RULE13]
      else if (st_q == ST_SWAP)  dg_q <= DG_SWAP;
      else if (st_q == ST_NOCFG) dg_q <= DG_NOCFG;
      else if (|lost_q)          dg_q <= DG_MOD;
      else if (|rem_q)           dg_q <= DG_SUB;
      else if (cz[0] || cz[1])   dg_q <= DG_LINE;
      else if (head_fault)       dg_q <= DG_HEAD;
      else                       dg_q <= DG_NONE;
    end
  end

  assign rdata         = rd_q;
  assign sub_out       = sub_q;
  assign slot_red      = red_q;
  assign slot_grn      = grn_q;
  assign sys_fault_red = sf_q;
  assign mod_active    = act_q;
  assign out_data      = out_q;
  assign status_byte   = sb_q;
  assign diag_byte     = dg_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  topo_store_a: assert property ( // [RULE1]
    st_q == ST_BOOT && !vld_q && cfg_match && !sys_restart
    |=> vld_q && st_q == ST_RUN && topo_q == $past(topo_now))
    else $error("topology not stored at first start");
  topo_swap_a: assert property ( // [RULE2]
    st_q == ST_BOOT && vld_q && !sys_restart && topo_now != topo_q
    |=> st_q == ST_SWAP ##2 status_byte[SB_GEN])
    else $error("changed topology not flagged");
  topo_resume_a: assert property ( // [RULE4]
    st_q == ST_BOOT && vld_q && !sys_restart && topo_ok
    |=> st_q == ST_RUN)
    else $error("matching topology did not resume");
  fac_clear_a: assert property ( // [RULE6]
    sys_restart && fac_q |=> !vld_q && st_q == ST_BOOT)
    else $error("factory reset kept stored topology");
  slot_show_a: assert property ( // [RULE7]
    rem_q[0] |=> (slot_red[0] ^ slot_grn[0]) && sys_fault_red)
    else $error("removed slot not indicated");
  sub_clear_a: assert property ( // [RULE8]
    !sub_present[0] && sub_safe[0] |=> sub_out[0] == 1'b0)
    else $error("safety bit of removed slot kept");
  chain_down_a: assert property ( // [RULE11]
    !mod_link[1] ##1 !sys_restart[*3] |=> mod_active[NMOD-1:1] == '0)
    else $error("downstream modules stayed active");
  out_zero_a: assert property ( // [RULE12]
    !iops_good |=> out_data == '0)
    else $error("output data not cleared on stop");
  run_bit_a: assert property ( // [RULE14]
    st_q != ST_RUN |=> !status_byte[SB_RUN])
    else $error("run bit set while not running");
  ack_clear_a: assert property ( // [RULE17]
    ack_fire && ((cz & ~cz_q) == 4'h0) |=> err_q == 4'h0)
    else $error("held ack did not clear errors");
  ack_short_a: assert property ( // [RULE21]
    err_q[3] && cz[3] && ack_in && (ack_cnt_q < ACK_T)
    |=> err_q[3])
    else $error("short ack cleared error");

  store_c: cover property (st_q == ST_BOOT && !vld_q ##1 vld_q);
  swap_c:  cover property (st_q == ST_SWAP);
  slot_c:  cover property (rem_q[0] ##1 !rem_q[0]);
  ack_c:   cover property (ack_fire && err_q[3]);
endmodule

/* hw/bmss_pkg.sv */
/*
 * bmss_pkg: constants, state codes and carriers of the bus module
 * status supervisor. Assumes one 125 MHz clock and a plain register port.
 */
package bmss_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam int        ADDR_W     = 4;
  localparam logic [3:0] A_CTRL    = 4'h0;
  localparam logic [3:0] A_STAT    = 4'h4;
  localparam logic [3:0] A_FL_SLOT = 4'h8;
  localparam logic [3:0] A_FL_SF   = 4'hC;
  localparam int        CTRL_EXT   = 0;     // extended diag layout
  localparam logic [7:0] FL_RST    = 8'h0A; // 1.0 Hz after reset
  localparam logic [7:0] FL_MIN    = 8'h01;
  // status byte bit positions toward the controller
  localparam int SB_RUN = 0;
  localparam int SB_ML1 = 1;
  localparam int SB_ML2 = 2;
  localparam int SB_SYS = 5;
  localparam int SB_GEN = 7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ_DEF  = 125_000_000;
  localparam int ACK_HOLD_MS = 100;
  localparam int MS_PER_S    = 1000;
  localparam int TENTHS_HALF = 5;  // half period in tenths of a hertz
  // ---------------------------------------------------------------
  // diagnostic error codes
  // ---------------------------------------------------------------
  localparam logic [7:0] DG_NONE  = 8'h00;
  localparam logic [7:0] DG_SWAP  = 8'h01;
  localparam logic [7:0] DG_NOCFG = 8'h02;
  localparam logic [7:0] DG_MOD   = 8'h03;
  localparam logic [7:0] DG_SUB   = 8'h04;
  localparam logic [7:0] DG_LINE  = 8'h05;
  localparam logic [7:0] DG_HEAD  = 8'h06;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_SWAP  = 2'b10,
    ST_NOCFG = 2'b11
  } bmss_state_t;

  // causes of a per-line error
  typedef struct packed {
    logic mod_fault;
    logic sub_fault;
    logic emc;
    logic cable;
  } bmss_line_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } bmss_req_t;
endpackage

/* verif/bmss_plc_model.sv */
/*
 * bmss_plc_model: controller at the fieldbus side of the supervisor.
 * Assumes the bench commands link, run state, data and ack length.
 */
`timescale 1ns/1ps
module bmss_plc_model (
  input  wire logic       clock,     // shared clock
  input  wire logic       rst_n,     // power-up reset
  input  wire logic       link_up,   // bench: cable plugged
  input  wire logic       run,       // bench: controller running
  input  wire logic [7:0] data,      // bench: output data
  input  wire logic       ack_go,    // bench: start an ack
  input  wire logic [7:0] ack_len,   // bench: ack length, cycles
  output logic            link_pin,  // link up to the head
  output logic            iops_good, // provider status
  output logic [7:0]      plc_out,   // output data
  output logic            ack_in     // general_ack_bit
);
  logic [7:0] ack_cnt_q; // ack cycles still to hold

  // ----------------------------------------------
  // link and data
  // ----------------------------------------------
  // a stopped controller sends a changing pattern, so zeros must come
  // from the head and not from us
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_pin  <= 1'b0;
      iops_good <= 1'b0;
      plc_out   <= 8'h5A;
    end else begin
      link_pin  <= link_up;
      iops_good <= run;
      plc_out   <= run ? data : ~plc_out;
    end
  end

  // ----------------------------------------------
  // acknowledgment
  // ----------------------------------------------
  // held a full ack_len cycles; shorter than the minimum only on command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_cnt_q <= 8'h00;
    end else if (ack_go) begin
      ack_cnt_q <= ack_len;
    end else if (ack_cnt_q != 8'h00) begin
      ack_cnt_q <= ack_cnt_q - 8'h01;
    end
  end
  assign ack_in = (ack_cnt_q != 8'h00);
endmodule

/* verif/tb_bus_module_status_supervisor.sv */
/*
 * tb_bus_module_status_supervisor: directed tests of bmss_top with a
 * controller model. Assumes short counts: CLK_HZ 200, ACK_CYC 20.
 */
`timescale 1ns/1ps
module tb_bus_module_status_supervisor;
  import bmss_pkg::*;
  localparam int LIMIT = 20000; // tests need about 330 cycles
  logic             clock, rst_n, sys_restart, factory_sw, safe_diff;
  logic             cfg_match, head_fault, link_pin, iops_good, ack_in;
  logic             sys_fault_red, link_up, run, ack_go;
  bmss_req_t        req;
  logic [31:0]      rdata, topo_now, d;
  logic [3:0]       sub_present, sub_match, sub_safe, sub_bits, sub_out;
  logic [3:0]       slot_red, slot_grn, mod_link, mod_active;
  bmss_line_t [1:0] line_cause;
  logic [7:0]       plc_out, out_data, data, ack_len, status_byte;
  logic [7:0]       diag_byte;
  int               error_cnt, checks, cyc, n;

  bmss_top #(.CLK_HZ(200), .ACK_CYC(20)) uut (
    .clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .sys_restart(sys_restart), .factory_sw(factory_sw),
    .topo_now(topo_now), .safe_diff(safe_diff), .cfg_match(cfg_match),
    .sub_present(sub_present), .sub_match(sub_match),
    .sub_safe(sub_safe), .sub_bits(sub_bits), .sub_out(sub_out),
    .slot_red(slot_red), .slot_grn(slot_grn),
    .sys_fault_red(sys_fault_red), .mod_link(mod_link),
    .mod_active(mod_active), .line_cause(line_cause),
    .head_fault(head_fault), .link_pin(link_pin),
    .iops_good(iops_good), .plc_out(plc_out), .out_data(out_data),
    .ack_in(ack_in), .status_byte(status_byte), .diag_byte(diag_byte));

  bmss_plc_model plc (
    .clock(clock), .rst_n(rst_n), .link_up(link_up), .run(run),
    .data(data), .ack_go(ack_go), .ack_len(ack_len),
    .link_pin(link_pin), .iops_good(iops_good), .plc_out(plc_out),
    .ack_in(ack_in));

  // ----------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------
  always #4 clock = ~clock;

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc >= LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clock);
    req <= '0;
    #1 v = rdata;
  endtask

  task automatic restart();
    @(posedge clock);
    sys_restart <= 1'b1;
    @(posedge clock);
    sys_restart <= 1'b0;
    tick(10);
  endtask

  task automatic ack(input logic [7:0] k);
    @(posedge clock);
    ack_len <= k;
    ack_go  <= 1'b1;
    @(posedge clock);
    ack_go  <= 1'b0;
    tick(k + 6);
  endtask

  // ----------------------------------------------
  // test sequence
  // ----------------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    sys_restart = 1'b0;
    factory_sw = 1'b0;
    topo_now = 32'h0000_0123;
    safe_diff = 1'b0;
    cfg_match = 1'b1;
    sub_present = 4'hF;
    sub_match = 4'hF;
    sub_safe = 4'hF;
    sub_bits = 4'hF;
    mod_link = 4'hF;
    line_cause = '0;
    head_fault = 1'b0;
    {link_up, run, ack_go} = 3'b000;
    data = 8'hA5;
    ack_len = 8'h00;
    {error_cnt, checks, cyc} = 0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    check(out_data, 8'h00, "out at power-up");
    check(status_byte, 8'h00, "status at power-up");
    rd(A_STAT, d);
    check(d[25:24], ST_RUN, "first start");
    link_up <= 1'b1;
    run <= 1'b1;
    tick(8);
    check(out_data, 8'hA5, "out follows");
    check(status_byte, 8'h01, "run only");
    rd(A_FL_SLOT, d);
    check(d[7:0], FL_RST, "flash reset");
    wr(A_FL_SLOT, 32'h0000_00FF);
    wr(A_FL_SF, 32'h0000_0001);
    rd(A_FL_SLOT, d);
    check(d[7:0], 8'hFF, "flash max");
    rd(A_FL_SF, d);
    check(d[7:0], FL_MIN, "flash min");
    rd(4'h2, d);
    check(d, 32'h0000_0000, "unmapped");
    wr(A_CTRL, 32'h0000_0001);
    run <= 1'b0;
    tick(4);
    check(out_data, 8'h00, "plc stop");
    run <= 1'b1;
    link_up <= 1'b0;
    tick(8);
    check(out_data, 8'h00, "link lost");
    check(status_byte[0], 1'b0, "no run");
    link_up <= 1'b1;
    topo_now <= 32'h0000_0321;
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_SWAP, "moved device");
    check(diag_byte, DG_SWAP, "diag swap");
    topo_now <= 32'h0000_1123;
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_SWAP, "added device");
    topo_now <= 32'h0000_0123;
    safe_diff <= 1'b1;
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_SWAP, "major safe diff");
    safe_diff <= 1'b0;
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_RUN, "topology back");
    factory_sw <= 1'b1;
    topo_now <= 32'h0000_0456;
    tick(4);
    restart();
    factory_sw <= 1'b0;
    tick(4);
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_RUN, "relearned");
    topo_now <= 32'h0000_0123;
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_SWAP, "old one gone");
    topo_now <= 32'h0000_0456;
    restart();
    // red and green alternate, so look for either and then for green
    sub_present <= 4'hE;
    tick(3);
    check(sub_out[0], 1'b0, "safe bit cleared");
    check(slot_red[0] | slot_grn[0], 1'b1, "slot lit");
    check(sys_fault_red, 1'b1, "fault red");
    check(diag_byte, DG_SUB, "diag slot");
    n = 0;
    while (slot_grn[0] !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check(slot_grn[0], 1'b1, "green flash");
    sub_present <= 4'hF;
    sub_bits <= 4'hE;
    tick(4);
    check(sub_out, 4'hE, "bit live again");
    check({slot_red[0], slot_grn[0]}, 2'b00, "slot off");
    check(sys_fault_red, 1'b0, "fault off");
    mod_link <= 4'hD;
    tick(8);
    check(mod_active, 4'h1, "downstream off");
    check(diag_byte, DG_MOD, "diag module");
    mod_link <= 4'hF;
    tick(8);
    check(mod_active, 4'h1, "stays off");
    restart();
    check(mod_active, 4'hF, "back on restart");
    head_fault <= 1'b1;
    tick(4);
    check(status_byte, 8'hA1, "head error");
    check(diag_byte, DG_HEAD, "diag head");
    ack(8'd10);
    check(status_byte[7], 1'b1, "short ack");
    ack(8'd20);
    check(status_byte, 8'h01, "full ack");
    head_fault <= 1'b0;
    // let the system cause drop first, so the line cause is a new edge
    tick(2);
    for (int i = 0; i < 4; i++) begin
      line_cause[0] <= bmss_line_t'(4'h1 << i);
      tick(4);
      check(status_byte, 8'h23, "line one");
      line_cause[0] <= '0;
      tick(4);
      check(status_byte, 8'h01, "cause gone");
    end
    line_cause[1].cable <= 1'b1;
    tick(4);
    check(status_byte, 8'h25, "line two");
    check(diag_byte, DG_LINE, "diag line");
    line_cause[1] <= '0;
    factory_sw <= 1'b1;
    cfg_match <= 1'b0;
    tick(4);
    restart();
    rd(A_STAT, d);
    check(d[25:24], ST_NOCFG, "config mismatch");
    check(diag_byte, DG_NOCFG, "diag no config");
    wr(A_CTRL, 32'h0000_0000);
    tick(4);
    check(diag_byte, DG_NONE, "basic layout");
    tally_and_finish();
  end
endmodule
